// ---- rtl/pmm_power_mode_manager.sv ----
module pmm_power_mode_manager #(
   parameter int NPERIPH = pmm_pkg::PMM_NPERIPH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire pmm_pkg::pmm_req_s modeReq,
   input wire logic [NPERIPH-1:0] periphEn,
   input wire logic [NPERIPH-1:0] sleepEn,
   input wire logic [NPERIPH-1:0] periphBusy,
   input wire logic [NPERIPH-1:0] periphIrq,
   input wire logic [NPERIPH-1:0] periphAck,
   input wire logic irqPending,
   input wire logic watchdogEvt,
   input wire logic nmiPin_n,
   input wire logic extWakePin,
   input wire logic memReq,
   output logic cpuClkEn,
   output logic memGrant,
   output logic sysClkEn,
   output logic [NPERIPH-1:0] perClkEn,
   output logic [NPERIPH-1:0] suspend,
   output pmm_pkg::pmm_mode_e curMode
);
   import pmm_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      pmm_state_e st;
      pmm_mode_e target;
      logic [3:0] cnt;
      logic [2:0] nmiSync;
      logic [1:0] extSync;
      logic cpuClkEn;
      logic memGrant;
      logic sysClkEn;
      logic [NPERIPH-1:0] perClkEn;
      logic [NPERIPH-1:0] suspend;
      pmm_mode_e mode;
   } pmm_state_s;

   pmm_state_s s_reg;
   pmm_state_s s_next;
   logic nmiFall;
   logic wakeIdle;
   logic wakeSleep;
   logic extWake;
   logic [NPERIPH-1:0] keep;

   // ****************************************
   // Wake decoding
   // ****************************************
   // Only nmiSync[2:1] are looked at; bit 0 is the first sync stage
   assign nmiFall = s_reg.nmiSync[2] & ~s_reg.nmiSync[1];
   assign extWake = s_reg.extSync[1];
   assign keep = periphEn & sleepEn;
   assign wakeIdle = irqPending | watchdogEvt | nmiFall;
   assign wakeSleep = (|(periphIrq & keep)) | watchdogEvt | nmiFall;

   always_comb begin
      s_next = s_reg;
      s_next.nmiSync = {s_reg.nmiSync[1:0], nmiPin_n};
      s_next.extSync = {s_reg.extSync[0], extWakePin};
      unique case (s_reg.st)
         PMM_S_RUN: begin
            if (modeReq.valid) begin
               unique case (modeReq.mode)
                  PMM_IDLE: s_next.st = PMM_S_IDLE;
                  PMM_SLEEP, PMM_DEEP: begin
                     s_next.st = PMM_S_SUSPEND;
                     s_next.target = modeReq.mode;
                  end
                  PMM_RUN: s_next.st = PMM_S_RUN;
               endcase
            end
         end
         PMM_S_IDLE: begin
            if (wakeIdle) begin
               s_next.st = PMM_S_RUN;
            end
         end
         PMM_S_SUSPEND: begin
            // Waits for peripherals to confirm they parked before clocks stop
            if (wakeSleep) begin
               s_next.st = PMM_S_RUN;
            end else if ((periphAck | keep) == {NPERIPH{1'b1}} ||
                         (periphAck & ~keep) == ~keep) begin
               s_next.st = PMM_S_DRAIN;
               s_next.cnt = PMM_DRAIN_W;
            end
         end
         PMM_S_DRAIN: begin
            if (wakeSleep) begin
               s_next.st = PMM_S_RUN;
            end else if (s_reg.cnt <= 4'h1) begin
               s_next.st = (s_reg.target == PMM_DEEP) ? PMM_S_DEEP : PMM_S_SLEEP;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         PMM_S_SLEEP: begin
            if (wakeSleep) begin
               s_next.st = PMM_S_RUN;
            end
         end
         PMM_S_DEEP: begin
            if (extWake) begin
               s_next.st = PMM_S_RUN;
            end
         end
         default: s_next.st = PMM_S_RUN;
      endcase

      // ****************************************
      // Gating outputs, from next state
      // ****************************************
      // Auto gating: a unit is clocked only while enabled and busy or requesting
      unique case (s_next.st)
         PMM_S_RUN: begin
            s_next.mode = PMM_RUN;
            s_next.cpuClkEn = 1'b1;
            s_next.memGrant = memReq;
            s_next.sysClkEn = 1'b1;
            s_next.perClkEn = periphEn & (periphBusy | periphIrq);
            s_next.suspend = '0;
         end
         PMM_S_IDLE: begin
            s_next.mode = PMM_IDLE;
            s_next.cpuClkEn = 1'b0;
            s_next.memGrant = memReq;
            s_next.sysClkEn = 1'b1;
            s_next.perClkEn = periphEn & (periphBusy | periphIrq);
            s_next.suspend = '0;
         end
         PMM_S_SUSPEND, PMM_S_DRAIN: begin
            s_next.mode = PMM_RUN;
            s_next.cpuClkEn = 1'b1;
            s_next.memGrant = memReq;
            s_next.sysClkEn = 1'b1;
            s_next.perClkEn = periphEn & (periphBusy | periphIrq);
            s_next.suspend = ~keep;
         end
         PMM_S_SLEEP: begin
            s_next.mode = PMM_SLEEP;
            s_next.cpuClkEn = 1'b0;
            s_next.memGrant = 1'b0;
            s_next.sysClkEn = 1'b1;
            s_next.perClkEn = keep & (periphBusy | periphIrq);
            s_next.suspend = ~keep;
         end
         PMM_S_DEEP: begin
            s_next.mode = PMM_DEEP;
            s_next.cpuClkEn = 1'b0;
            s_next.memGrant = 1'b0;
            s_next.sysClkEn = 1'b0;
            s_next.perClkEn = '0;
            s_next.suspend = {NPERIPH{1'b1}};
         end
         default: begin
            s_next.mode = PMM_RUN;
            s_next.cpuClkEn = 1'b1;
            s_next.memGrant = 1'b0;
            s_next.sysClkEn = 1'b1;
            s_next.perClkEn = '0;
            s_next.suspend = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Reset returns to run with CPU and system clocks on; peripheral clocks gated off, none suspended
         s_reg.st <= PMM_S_RUN;
         s_reg.target <= PMM_RUN;
         s_reg.cnt <= 4'h0;
         s_reg.nmiSync <= 3'h7;
         s_reg.extSync <= 2'h0;
         s_reg.cpuClkEn <= 1'b1;
         s_reg.memGrant <= 1'b0;
         s_reg.sysClkEn <= 1'b1;
         s_reg.perClkEn <= '0;
         s_reg.suspend <= '0;
         s_reg.mode <= PMM_RUN;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cpuClkEn = s_reg.cpuClkEn;
   assign memGrant = s_reg.memGrant;
   assign sysClkEn = s_reg.sysClkEn;
   assign perClkEn = s_reg.perClkEn;
   assign suspend = s_reg.suspend;
   assign curMode = s_reg.mode;
endmodule : pmm_power_mode_manager

// ---- rtl/pmm_pkg.sv ----
package pmm_pkg;
   // ****************************************
   // Modes and states
   // ****************************************
   typedef enum logic [1:0] {
      PMM_RUN,
      PMM_IDLE,
      PMM_SLEEP,
      PMM_DEEP
   } pmm_mode_e;
   typedef enum logic [2:0] {
      PMM_S_RUN,
      PMM_S_IDLE,
      PMM_S_SUSPEND,
      PMM_S_DRAIN,
      PMM_S_SLEEP,
      PMM_S_DEEP
   } pmm_state_e;
   // ****************************************
   // Constants
   // ****************************************
   localparam int PMM_NPERIPH = 8;
   localparam int PMM_DRAIN_NS = 200;
   localparam int PMM_CLK_NS = 50;
   localparam int PMM_DRAIN_CYC = (PMM_DRAIN_NS + PMM_CLK_NS - 1) / PMM_CLK_NS;
   localparam logic [3:0] PMM_DRAIN_W = 4'h4;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic valid;
      pmm_mode_e mode;
   } pmm_req_s;
   typedef struct packed {
      logic cpuClkEn;
      logic memGrant;
      logic sysClkEn;
      logic [PMM_NPERIPH-1:0] perClkEn;
      logic [PMM_NPERIPH-1:0] suspend;
   } pmm_gate_s;
endpackage : pmm_pkg

// ---- verification/pmm_chk.sv ----
module pmm_chk #(
   parameter int NPERIPH = pmm_pkg::PMM_NPERIPH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NPERIPH-1:0] sleepEn,
   input wire logic [NPERIPH-1:0] periphEn,
   input wire logic [NPERIPH-1:0] periphBusy,
   input wire logic [NPERIPH-1:0] periphIrq,
   input wire logic watchdogEvt,
   input wire logic extWakePin,
   input wire logic memReq,
   input wire logic cpuClkEn,
   input wire logic memGrant,
   input wire logic sysClkEn,
   input wire logic [NPERIPH-1:0] perClkEn,
   input wire logic [NPERIPH-1:0] suspend,
   input wire pmm_pkg::pmm_mode_e curMode
);
   import pmm_pkg::*;
   // ****
   // Checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_run_clk: assert property (curMode == PMM_RUN |-> cpuClkEn && sysClkEn)
      else $error("run clock off");
   a_idle_gate: assert property (curMode == PMM_IDLE |-> !cpuClkEn && sysClkEn && !suspend)
      else $error("idle gating wrong");
   a_idle_mem: assert property (curMode == PMM_IDLE && memReq |=> memGrant)
      else $error("idle memory not granted");
   a_sleep_susp: assert property (curMode == PMM_SLEEP |-> &(suspend | sleepEn) && !cpuClkEn)
      else $error("sleep suspend missing");
   a_sleep_per: assert property (curMode == PMM_SLEEP |-> !(perClkEn & ~sleepEn))
      else $error("unkept peripheral clocked");
   a_wdog_wake: assert property (curMode inside {PMM_IDLE, PMM_SLEEP} && watchdogEvt
      |-> ##[1:2] curMode == PMM_RUN)
      else $error("watchdog wake late");
   a_deep_stop: assert property ((curMode == PMM_DEEP && !extWakePin) [*4]
      |=> curMode == PMM_DEEP && !sysClkEn)
      else $error("deep left without wake");
   // Core must stay clocked through the drain
   a_sleep_entry: assert property ($rose(curMode == PMM_SLEEP)
      |-> $past(cpuClkEn) && $past(cpuClkEn, 4))
      else $error("abrupt sleep entry");
   a_auto_gate: assert property (curMode == PMM_RUN && !suspend && $past(rst_n) && !$past(suspend)
      && $past(curMode) == PMM_RUN |-> perClkEn == $past(periphEn & (periphBusy | periphIrq)))
      else $error("auto gating wrong");
   c_idle: cover property (curMode == PMM_IDLE && memReq);
   c_sleep: cover property (curMode == PMM_SLEEP);
   c_deep: cover property (curMode == PMM_DEEP);
endmodule : pmm_chk
bind pmm_power_mode_manager pmm_chk #(.NPERIPH(NPERIPH)) pmm_chk_inst (.*);

// ---- verification/pmm_periph_model.sv ----
module pmm_periph_model #(
   parameter int NPERIPH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] dly,
   input wire logic [NPERIPH-1:0] suspend,
   output logic [NPERIPH-1:0] periphAck
);
   // ****
   // Parking delay line
   // ****
   logic [NPERIPH-1:0] line [8];
   // Ack drops with suspend, so a stale park never leaks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line <= '{default: '0};
      end else begin
         line[0] <= suspend;
         for (int i = 1; i < 8; i++) begin
            line[i] <= line[i-1] & suspend;
         end
      end
   end
   assign periphAck = line[dly] & suspend;
endmodule : pmm_periph_model

// ---- verification/tb_power_mode_manager.sv ----
module tb_power_mode_manager;
   timeunit 1ns;
   timeprecision 1ns;
   import pmm_pkg::*;
   logic clk, rst_n, irqPending, watchdogEvt, nmiPin_n, extWakePin, memReq;
   logic cpuClkEn, memGrant, sysClkEn;
   logic [7:0] periphEn, sleepEn, periphBusy, periphIrq, periphAck, perClkEn, suspend;
   logic [2:0] dly;
   pmm_req_s modeReq;
   pmm_mode_e curMode;
   int nMismatch, numChecks;
   pmm_power_mode_manager pmm_power_mode_manager_inst (.*);
   pmm_periph_model pmm_periph_model_inst (.*);
   // ****
   // Helpers
   // ****
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : cyc
   task automatic waitMode(pmm_mode_e m);
      for (int i = 0; i < 60 && curMode !== m; i++) begin
         cyc(1);
      end
   endtask : waitMode
   task automatic req(pmm_mode_e m);
      modeReq = {1'b1, m};
      cyc(1);
      modeReq.valid = 0;
   endtask : req
   task automatic t_auto();
      {periphEn, periphBusy, periphIrq} = 24'h3C_0F10;
      req(PMM_RUN);
      cyc(2);
      chk({curMode, perClkEn}, {PMM_RUN, 8'h1C});
      periphIrq = 0;
   endtask : t_auto
   task automatic t_idle(logic [2:0] w);
      req(PMM_IDLE);
      waitMode(PMM_IDLE);
      chk({cpuClkEn, sysClkEn, curMode}, {2'b01, PMM_IDLE});
      memReq = 1;
      cyc(1);
      chk(memGrant, 1);
      {memReq, irqPending, watchdogEvt, nmiPin_n} = {1'b0, w};
      cyc(1);
      {irqPending, watchdogEvt, nmiPin_n} = 3'b001;
      waitMode(PMM_RUN);
      chk(curMode, PMM_RUN);
   endtask : t_idle
   task automatic t_sleep(logic [2:0] d);
      dly = d;
      {periphEn, sleepEn, periphBusy} = 24'hFF_0FFF;
      req(PMM_SLEEP);
      waitMode(PMM_SLEEP);
      chk({curMode, cpuClkEn, suspend}, {PMM_SLEEP, 1'b0, 8'hF0});
      cyc(1);
      chk(perClkEn, 8'h0F);
      irqPending = 1;
      cyc(3);
      chk(curMode, PMM_SLEEP);
      {irqPending, periphIrq} = 9'h001;
      cyc(1);
      periphIrq = 0;
      waitMode(PMM_RUN);
      chk({curMode, suspend}, {PMM_RUN, 8'h00});
   endtask : t_sleep
   task automatic t_abort();
      // Slow parking keeps the sequence open long enough to interrupt
      dly = 7;
      req(PMM_DEEP);
      cyc(2);
      watchdogEvt = 1;
      cyc(1);
      watchdogEvt = 0;
      cyc(12);
      chk({curMode, cpuClkEn, suspend}, {PMM_RUN, 1'b1, 8'h00});
   endtask : t_abort
   task automatic t_deep();
      dly = 0;
      req(PMM_DEEP);
      waitMode(PMM_DEEP);
      chk({sysClkEn, cpuClkEn, suspend}, 10'h0FF);
      {watchdogEvt, periphIrq} = 9'h1FF;
      cyc(1);
      {watchdogEvt, periphIrq} = 0;
      cyc(4);
      chk(curMode, PMM_DEEP);
      extWakePin = 1;
      cyc(2);
      extWakePin = 0;
      waitMode(PMM_RUN);
      chk(curMode, PMM_RUN);
   endtask : t_deep
   task automatic end_sim();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial begin
      #100000;
      nMismatch++;
      end_sim();
   end
   initial begin
      {rst_n, modeReq, irqPending, watchdogEvt, extWakePin, memReq} = 0;
      {periphEn, sleepEn, periphBusy, periphIrq} = 0;
      nmiPin_n = 1;
      dly = 0;
      repeat (12) @(posedge clk);
      #5;
      rst_n = 1;
      cyc(1);
      chk({curMode, cpuClkEn, sysClkEn}, {PMM_RUN, 2'b11});
      t_auto();
      t_idle(3'b101);
      t_idle(3'b011);
      t_idle(3'b000);
      t_sleep(0);
      t_sleep(5);
      t_abort();
      t_deep();
      end_sim();
   end
endmodule : tb_power_mode_manager
